/* rtl/coag_top.sv */
`default_nettype none
module coag_top
   import coag_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_req_valid,
   input wire coag_pkg::coag_req_t i_req,
   input wire logic i_idx_load,
   input wire logic [7:0] i_idx_hi,
   input wire logic [7:0] i_idx_lo,
   input wire logic i_sp_load,
   input wire logic [15:0] i_sp,
   input wire logic i_pc_load,
   input wire logic [15:0] i_pc,
   input wire logic i_alu_valid,
   input wire coag_pkg::coag_alu_t i_alu_op,
   input wire logic [7:0] i_alu_a,
   input wire logic [7:0] i_alu_b,
   input wire logic i_alu_bit,
   output logic o_resp_valid,
   output coag_pkg::coag_resp_t o_resp,
   output logic o_dest_valid,
   output logic [15:0] o_dest_addr,
   output logic [15:0] o_index_pair,
   output logic [15:0] o_stack_pointer,
   output logic [15:0] o_program_counter,
   output logic o_carry_borrow
);
   import coag_pkg::*;

   logic [7:0] idx_hi_reg;
   logic [7:0] idx_lo_reg;
   logic [15:0] sp_reg;
   logic [15:0] pc_reg;
   logic carry_reg;
   logic resp_valid_reg;
   coag_resp_t resp_reg;
   logic dest_valid_reg;
   logic [15:0] dest_reg;
   logic [15:0] index_pair;
   logic [15:0] ea_next;
   logic mem_next;
   logic post_inc;
   logic [15:0] operand_next;
   logic operand_ok;
   logic carry_next;

   // Wrapping 16-bit add; the carry out is dropped on purpose.
   function automatic logic [15:0] add16(input logic [15:0] a,
                                         input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0];
   endfunction

   // Joins a high and low byte into a word.
   function automatic logic [15:0] hilo(input logic [7:0] h,
                                        input logic [7:0] l);
      return {h, l};
   endfunction

   assign index_pair = hilo(idx_hi_reg, idx_lo_reg);

   // Effective address per mode, one 16-bit address for every location.
   always_comb
   begin
      ea_next = 16'h0000;
      mem_next = 1'b1;
      post_inc = 1'b0;
      operand_next = 16'h0000;
      operand_ok = 1'b0;
      case (i_req.mode)
         COAG_MODE_REG_ONLY:
         begin
            mem_next = 1'b0;
         end
         COAG_MODE_PC_OFS:
         begin
            mem_next = 1'b0;
            ea_next = add16(pc_reg,
                            {{8{i_req.byte1[7]}}, i_req.byte1});
         end
         COAG_MODE_INLINE:
         begin
            mem_next = 1'b0;
            operand_next = hilo(i_req.byte1, i_req.byte2);
            operand_ok = 1'b1;
         end
         COAG_MODE_ZERO_PAGE:
            ea_next = hilo(ZERO_PAGE_HI, i_req.byte1);
         COAG_MODE_FULL_ADDR:
            ea_next = hilo(i_req.byte1, i_req.byte2);
         COAG_MODE_IDX:
            ea_next = index_pair;
         COAG_MODE_IDX_INC:
         begin
            ea_next = index_pair;
            post_inc = 1'b1;
         end
         COAG_MODE_IDX_OFS8:
            ea_next = add16(index_pair, {8'h00, i_req.byte1});
         COAG_MODE_IDX_OFS8_INC:
         begin
            ea_next = add16(index_pair, {8'h00, i_req.byte1});
            post_inc = 1'b1;
         end
         COAG_MODE_IDX_OFS16:
            ea_next = add16(index_pair,
                            hilo(i_req.byte1, i_req.byte2));
         COAG_MODE_SP_OFS8:
            ea_next = add16(sp_reg, {8'h00, i_req.byte1});
         COAG_MODE_SP_OFS16:
            ea_next = add16(sp_reg, hilo(i_req.byte1, i_req.byte2));
         default:
            mem_next = 1'b0;
      endcase
   end

   // Source and destination answers are held apart so a move can carry both.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         resp_valid_reg <= 1'b0;
         resp_reg <= '0;
         dest_valid_reg <= 1'b0;
         dest_reg <= 16'h0000;
      end
      else if (i_ce)
      begin
         resp_valid_reg <= i_req_valid && !i_req.is_dest;
         dest_valid_reg <= i_req_valid && i_req.is_dest;
         if (i_req_valid && !i_req.is_dest)
         begin
            resp_reg.addr <= ea_next;
            resp_reg.mem_access <= mem_next;
            resp_reg.operand <= operand_next;
            resp_reg.operand_valid <= operand_ok;
         end
         if (i_req_valid && i_req.is_dest)
            dest_reg <= ea_next;
      end
   end

   // Index pair: loaded by the core, else bumped after a post-increment fetch.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         idx_hi_reg <= IDX_RESET[15:8];
         idx_lo_reg <= IDX_RESET[7:0];
      end
      else if (i_ce)
      begin
         if (i_idx_load)
         begin
            idx_hi_reg <= i_idx_hi;
            idx_lo_reg <= i_idx_lo;
         end
         else if (i_req_valid && post_inc)
         begin
            {idx_hi_reg, idx_lo_reg} <= add16(index_pair, POST_INC);
         end
      end
   end

   // Stack pointer is only ever loaded by the core here.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         sp_reg <= SP_RESET;
      else if (i_ce && i_sp_load)
         sp_reg <= i_sp;
   end

   // A taken branch moves the counter to the relative target.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         pc_reg <= PC_RESET;
      else if (i_ce)
      begin
         if (i_pc_load)
            pc_reg <= i_pc;
         else if (i_req_valid && i_req.mode == COAG_MODE_PC_OFS
                  && i_req.branch_taken)
            pc_reg <= ea_next;
      end
   end

   // Carry from add, borrow from subtract, shifted-out bit or tested bit.
   always_comb
   begin
      logic [8:0] sum;
      sum = 9'h000;
      carry_next = carry_reg;
      case (i_alu_op)
         COAG_ALU_ADD:
         begin
            sum = {1'b0, i_alu_a} + {1'b0, i_alu_b};
            carry_next = sum[8];
         end
         COAG_ALU_SUB:
            carry_next = i_alu_a < i_alu_b;
         COAG_ALU_SHL:
            carry_next = i_alu_a[CARRY_BIT];
         COAG_ALU_SHR:
            carry_next = i_alu_a[0];
         COAG_ALU_BITTEST:
            carry_next = i_alu_bit;
         default:
            carry_next = carry_reg;
      endcase
   end

   // The flag moves only on an ALU step, so address work leaves it alone.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         carry_reg <= 1'b0;
      else if (i_ce && i_alu_valid)
         carry_reg <= carry_next;
   end

   assign o_resp_valid = resp_valid_reg;
   assign o_resp = resp_reg;
   assign o_dest_valid = dest_valid_reg;
   assign o_dest_addr = dest_reg;
   assign o_index_pair = index_pair;
   assign o_stack_pointer = sp_reg;
   assign o_program_counter = pc_reg;
   assign o_carry_borrow = carry_reg;

   // Checks on the answers one cycle after an accepted request or ALU step.
   sequence req_s(coag_mode_t m);
      i_ce && i_req_valid && !i_req.is_dest && i_req.mode == m;
   endsequence

   // A post-increment fetch with no competing load of the index pair.
   sequence inc_s(coag_mode_t m);
      req_s(m) ##0 !i_idx_load;
   endsequence

   carry_add_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      i_ce && i_alu_valid && i_alu_op == COAG_ALU_ADD |=> o_carry_borrow ==
      (({1'b0, $past(i_alu_a)} + {1'b0, $past(i_alu_b)}) > 9'h0FF))
      else $error("carry after add wrong");
   carry_sub_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      i_ce && i_alu_valid && i_alu_op == COAG_ALU_SUB |=>
      o_carry_borrow == ($past(i_alu_a) < $past(i_alu_b)))
      else $error("borrow after subtract wrong");
   reg_only_a: assert property (@(posedge i_clk) disable iff (i_reset)
      req_s(COAG_MODE_REG_ONLY) |=> o_resp_valid && !o_resp.mem_access)
      else $error("register mode touched memory");
   zero_page_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      req_s(COAG_MODE_ZERO_PAGE) |=> o_resp.addr[15:8] == 8'h00 &&
      o_resp.addr[7:0] == $past(i_req.byte1))
      else $error("zero page address wrong");
   full_addr_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      req_s(COAG_MODE_FULL_ADDR) |=> o_resp.addr ==
      {$past(i_req.byte1), $past(i_req.byte2)})
      else $error("full address byte order wrong");
   idx_inc_a: assert property (@(posedge i_clk) disable iff (i_reset)
      inc_s(COAG_MODE_IDX_INC) |=>
      o_resp.addr == $past(o_index_pair) &&
      o_index_pair == 16'($past(o_index_pair) + 16'h0001))
      else $error("index post increment wrong");
   idx_ofs8_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      req_s(COAG_MODE_IDX_OFS8) |=> o_resp.addr ==
      16'($past(o_index_pair) + {8'h00, $past(i_req.byte1)}))
      else $error("index short offset wrong");
   sp_ofs16_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      req_s(COAG_MODE_SP_OFS16) |=> o_resp.addr == 16'($past(o_stack_pointer)
      + {$past(i_req.byte1), $past(i_req.byte2)}))
      else $error("stack long offset wrong");
   branch_target_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      i_ce && i_req_valid && i_req.mode == COAG_MODE_PC_OFS &&
      i_req.branch_taken && !i_pc_load |=> o_program_counter ==
      16'($past(o_program_counter) + {{8{$past(i_req.byte1[7])}},
      $past(i_req.byte1)}))
      else $error("branch target wrong");

   // Remaining forms, plus checks on the pair load, the untaken branch and the left-shift carry.
   inline_opnd_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      req_s(COAG_MODE_INLINE) |=> o_resp.operand_valid &&
      o_resp.operand == {$past(i_req.byte1), $past(i_req.byte2)})
      else $error("inline operand wrong");
   idx_plain_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      req_s(COAG_MODE_IDX) |=> o_resp.addr == $past(o_index_pair))
      else $error("index pair address wrong");
   idx_ofs8_inc_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      inc_s(COAG_MODE_IDX_OFS8_INC) |=> o_resp.addr ==
      16'($past(o_index_pair) + {8'h00, $past(i_req.byte1)}) &&
      o_index_pair == 16'($past(o_index_pair) + 16'h0001))
      else $error("index short offset increment wrong");
   idx_ofs16_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      req_s(COAG_MODE_IDX_OFS16) |=> o_resp.addr == 16'($past(o_index_pair)
      + {$past(i_req.byte1), $past(i_req.byte2)}))
      else $error("index long offset wrong");
   sp_ofs8_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      req_s(COAG_MODE_SP_OFS8) |=> o_resp.addr ==
      16'($past(o_stack_pointer) + {8'h00, $past(i_req.byte1)}))
      else $error("stack short offset wrong");
   dest_addr_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      i_ce && i_req_valid && i_req.is_dest &&
      i_req.mode == COAG_MODE_FULL_ADDR |=> o_dest_valid && !o_resp_valid &&
      o_dest_addr == {$past(i_req.byte1), $past(i_req.byte2)})
      else $error("move destination address wrong");
   pair_load_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      i_ce && i_idx_load |=> o_index_pair ==
      {$past(i_idx_hi), $past(i_idx_lo)})
      else $error("index pair halves swapped");
   branch_hold_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      i_ce && i_req_valid && i_req.mode == COAG_MODE_PC_OFS &&
      !i_req.branch_taken && !i_pc_load |=> $stable(o_program_counter))
      else $error("untaken branch moved the counter");
   shift_carry_a: assert property (@(posedge i_clk)
      disable iff (i_reset)
      i_ce && i_alu_valid && i_alu_op == COAG_ALU_SHL |=>
      o_carry_borrow == $past(i_alu_a[CARRY_BIT]))
      else $error("carry after shift wrong");
endmodule
`default_nettype wire

/* rtl/coag_pkg.sv */
`default_nettype none
package coag_pkg;
   localparam int ADDR_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [7:0] ZERO_PAGE_HI = 8'h00;
   localparam logic [15:0] POST_INC = 16'h0001;
   localparam int CARRY_BIT = 7;
   localparam logic [15:0] IDX_RESET = 16'h0000;
   localparam logic [15:0] SP_RESET = 16'h00FF;
   localparam logic [15:0] PC_RESET = 16'h0000;

   typedef enum logic [3:0] {
      COAG_MODE_REG_ONLY,
      COAG_MODE_PC_OFS,
      COAG_MODE_INLINE,
      COAG_MODE_ZERO_PAGE,
      COAG_MODE_FULL_ADDR,
      COAG_MODE_IDX,
      COAG_MODE_IDX_INC,
      COAG_MODE_IDX_OFS8,
      COAG_MODE_IDX_OFS8_INC,
      COAG_MODE_IDX_OFS16,
      COAG_MODE_SP_OFS8,
      COAG_MODE_SP_OFS16
   } coag_mode_t;

   typedef enum logic [2:0] {
      COAG_ALU_NONE,
      COAG_ALU_ADD,
      COAG_ALU_SUB,
      COAG_ALU_SHL,
      COAG_ALU_SHR,
      COAG_ALU_BITTEST
   } coag_alu_t;

   typedef struct packed {
      coag_mode_t mode;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic is_dest;
      logic branch_taken;
   } coag_req_t;

   typedef struct packed {
      logic [15:0] addr;
      logic mem_access;
      logic [15:0] operand;
      logic operand_valid;
   } coag_resp_t;
endpackage
`default_nettype wire

/* sim/coag_mem_model.sv */
`default_nettype none
module coag_mem_model
   import coag_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_resp_valid,
   input wire coag_pkg::coag_resp_t i_resp,
   input wire logic i_dest_valid,
   input wire logic [15:0] i_dest_addr,
   output logic [15:0] o_access_count,
   output logic [15:0] o_last_addr
);
   timeunit 1ns;
   timeprecision 100ps;
   // One flat 64-Kbyte space needs no bank or page state, so the model
   // keeps only the last 16-bit address touched and a count of accesses.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_access_count <= 16'h0000;
         o_last_addr <= 16'h0000;
      end
      else if (i_dest_valid)
      begin
         o_access_count <= o_access_count + 16'h0001;
         o_last_addr <= i_dest_addr;
      end
      else if (i_resp_valid && i_resp.mem_access)
      begin
         o_access_count <= o_access_count + 16'h0001;
         o_last_addr <= i_resp.addr;
      end
   end
endmodule
`default_nettype wire

/* sim/tb.sv */
`default_nettype none
module tb;
   import coag_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_req_valid = 1'b0;
   coag_req_t i_req = '0;
   logic i_idx_load = 1'b0, i_sp_load = 1'b0, i_pc_load = 1'b0;
   logic [7:0] i_idx_hi = 8'h00, i_idx_lo = 8'h00;
   logic [15:0] i_sp = 16'h0000, i_pc = 16'h0000;
   logic i_alu_valid = 1'b0, i_alu_bit = 1'b0;
   coag_alu_t i_alu_op = COAG_ALU_NONE;
   logic [7:0] i_alu_a = 8'h00, i_alu_b = 8'h00;
   logic o_resp_valid, o_dest_valid, o_carry_borrow;
   coag_resp_t o_resp;
   logic [15:0] o_dest_addr, o_index_pair, o_stack_pointer;
   logic [15:0] o_program_counter, acc_cnt, last_addr;
   int err_total = 0, check_count = 0;
   coag_top u_coag_top (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
      .i_req_valid(i_req_valid), .i_req(i_req), .i_idx_load(i_idx_load),
      .i_idx_hi(i_idx_hi), .i_idx_lo(i_idx_lo), .i_sp_load(i_sp_load),
      .i_sp(i_sp), .i_pc_load(i_pc_load), .i_pc(i_pc),
      .i_alu_valid(i_alu_valid), .i_alu_op(i_alu_op), .i_alu_a(i_alu_a),
      .i_alu_b(i_alu_b), .i_alu_bit(i_alu_bit),
      .o_resp_valid(o_resp_valid), .o_resp(o_resp),
      .o_dest_valid(o_dest_valid), .o_dest_addr(o_dest_addr),
      .o_index_pair(o_index_pair), .o_stack_pointer(o_stack_pointer),
      .o_program_counter(o_program_counter),
      .o_carry_borrow(o_carry_borrow));
   coag_mem_model u_coag_mem_model (.i_clk(i_clk), .i_reset(i_reset),
      .i_resp_valid(o_resp_valid), .i_resp(o_resp),
      .i_dest_valid(o_dest_valid), .i_dest_addr(o_dest_addr),
      .o_access_count(acc_cnt), .o_last_addr(last_addr));
   // Free-running 125 MHz clock.
   always #4 i_clk = ~i_clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Request held one edge; the answer is settled 1 ns after the next.
   task automatic req(input coag_mode_t m, input logic [7:0] b1, b2,
                      input logic d, t);
      @(posedge i_clk);
      i_req_valid <= 1'b1;
      i_req <= {m, b1, b2, d, t};
      @(posedge i_clk);
      i_req_valid <= 1'b0;
      #1;
   endtask
   task automatic ea(input coag_mode_t m, input logic [7:0] b1, b2,
                     input logic [15:0] exp);
      req(m, b1, b2, 1'b0, 1'b0);
      chk(o_resp_valid, 1'b1);
      chk(o_resp.addr, exp);
      chk(o_resp.mem_access, 1'b1);
   endtask
   task automatic ld(input logic [15:0] x, sp, pc);
      @(posedge i_clk);
      {i_idx_load, i_sp_load, i_pc_load} <= 3'b111;
      {i_idx_hi, i_idx_lo} <= x;
      i_sp <= sp;
      i_pc <= pc;
      @(posedge i_clk);
      {i_idx_load, i_sp_load, i_pc_load} <= 3'b000;
      #1;
   endtask
   task automatic alu(input coag_alu_t op, input logic [7:0] a, b,
                      input logic bt, c);
      @(posedge i_clk);
      i_alu_valid <= 1'b1;
      i_alu_op <= op;
      i_alu_a <= a;
      i_alu_b <= b;
      i_alu_bit <= bt;
      @(posedge i_clk);
      i_alu_valid <= 1'b0;
      #1;
      chk(o_carry_borrow, c);
   endtask
   // Sums chosen to wrap past 0xFFFF, where a 17-bit slip would show.
   task automatic t_modes();
      chk(o_stack_pointer, SP_RESET);
      ld(16'hFFF0, 16'hFFF8, 16'h1000);
      chk(o_index_pair, 16'hFFF0);
      ea(COAG_MODE_ZERO_PAGE, 8'hA5, 8'h77, 16'h00A5);
      ea(COAG_MODE_FULL_ADDR, 8'h12, 8'h34, 16'h1234);
      ea(COAG_MODE_IDX, 8'h55, 8'h66, 16'hFFF0);
      ea(COAG_MODE_IDX_OFS8, 8'h20, 8'h00, 16'h0010);
      ea(COAG_MODE_IDX_OFS16, 8'h12, 8'h34, 16'h1224);
      ea(COAG_MODE_SP_OFS8, 8'hFF, 8'h00, 16'h00F7);
      ea(COAG_MODE_SP_OFS16, 8'h80, 8'h10, 16'h8008);
      #8;
      chk(last_addr, 16'h8008);
   endtask
   task automatic t_postinc();
      ld(16'hFFFF, 16'h00FF, 16'h0000);
      ea(COAG_MODE_IDX_INC, 8'h00, 8'h00, 16'hFFFF);
      chk(o_index_pair, 16'h0000);
      ea(COAG_MODE_IDX_OFS8_INC, 8'h10, 8'h00, 16'h0010);
      chk(o_index_pair, 16'h0001);
   endtask
   // Inline and register-only requests must not reach the memory model.
   task automatic t_nomem();
      logic [15:0] n;
      #8;
      n = acc_cnt;
      req(COAG_MODE_INLINE, 8'hAB, 8'hCD, 1'b0, 1'b0);
      chk(o_resp.operand, 16'hABCD);
      chk({o_resp.operand_valid, o_resp.mem_access}, 2'b10);
      req(COAG_MODE_REG_ONLY, 8'h11, 8'h22, 1'b0, 1'b0);
      chk({o_resp_valid, o_resp.mem_access}, 2'b10);
      #8;
      chk(acc_cnt, n);
   endtask
   task automatic t_branch();
      ld(16'h0000, 16'h00FF, 16'h1000);
      ea(COAG_MODE_ZERO_PAGE, 8'h30, 8'h00, 16'h0030);
      req(COAG_MODE_PC_OFS, 8'hF0, 8'h00, 1'b0, 1'b1);
      chk(o_program_counter, 16'h0FF0);
      chk(o_resp.mem_access, 1'b0);
      req(COAG_MODE_PC_OFS, 8'h10, 8'h00, 1'b0, 1'b0);
      chk(o_program_counter, 16'h0FF0);
      req(COAG_MODE_PC_OFS, 8'h7F, 8'h00, 1'b0, 1'b1);
      chk(o_program_counter, 16'h106F);
   endtask
   task automatic t_move();
      ea(COAG_MODE_ZERO_PAGE, 8'h40, 8'h00, 16'h0040);
      req(COAG_MODE_FULL_ADDR, 8'h20, 8'h00, 1'b1, 1'b0);
      chk({o_dest_valid, o_resp_valid}, 2'b10);
      chk(o_dest_addr, 16'h2000);
      #8;
      chk(last_addr, 16'h2000);
   endtask
   // Each step flips the flag so a stuck carry cannot pass.
   task automatic t_carry();
      alu(COAG_ALU_ADD, 8'hFF, 8'h01, 1'b0, 1'b1);
      alu(COAG_ALU_ADD, 8'h7F, 8'h01, 1'b0, 1'b0);
      alu(COAG_ALU_SUB, 8'h00, 8'h01, 1'b0, 1'b1);
      alu(COAG_ALU_SUB, 8'h05, 8'h03, 1'b0, 1'b0);
      alu(COAG_ALU_SHL, 8'h80, 8'h00, 1'b0, 1'b1);
      alu(COAG_ALU_SHL, 8'h01, 8'h00, 1'b0, 1'b0);
      alu(COAG_ALU_SHR, 8'h01, 8'h00, 1'b0, 1'b1);
      alu(COAG_ALU_BITTEST, 8'h00, 8'h00, 1'b0, 1'b0);
      alu(COAG_ALU_BITTEST, 8'h00, 8'h00, 1'b1, 1'b1);
   endtask
   // Enable low must freeze all state; a mid-run reset then loads the reset values, 0x00FF for the stack pointer.
   task automatic t_hold();
      ld(16'h1234, 16'h5678, 16'h9ABC);
      @(posedge i_clk);
      i_ce <= 1'b0;
      req(COAG_MODE_IDX_INC, 8'h00, 8'h00, 1'b0, 1'b0);
      chk(o_resp_valid, 1'b0);
      chk(o_index_pair, 16'h1234);
      alu(COAG_ALU_ADD, 8'h01, 8'h01, 1'b0, 1'b1);
      @(posedge i_clk);
      i_ce <= 1'b1;
      i_reset <= 1'b1;
      @(posedge i_clk);
      i_reset <= 1'b0;
      #1;
      chk(o_index_pair, IDX_RESET);
      chk(o_stack_pointer, SP_RESET);
      chk(o_program_counter, PC_RESET);
      chk({o_resp_valid, o_dest_valid, o_carry_borrow}, 3'b000);
      chk(o_resp.addr, 16'h0000);
      ea(COAG_MODE_ZERO_PAGE, 8'h5A, 8'h00, 16'h005A);
   endtask
   // The whole run is about a hundred cycles; this bound is generous.
   initial
   begin
      #200000;
      err_total++;
      stop_test();
   end
   initial
   begin
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
      t_modes();
      t_postinc();
      t_nomem();
      t_branch();
      t_move();
      t_carry();
      t_hold();
      stop_test();
   end
endmodule
`default_nettype wire
